// *** rtl/sdd_params.svh ***
// constants and notes for the step and direction input decoder
// ****************************************************************
// ****************************************************************
`ifndef SDD_PARAMS_SVH
`define SDD_PARAMS_SVH
`define SDD_CLK_HZ 40000000
`define SDD_IDLE_US 500
`define SDD_IDLE_CYC ((`SDD_IDLE_US * (`SDD_CLK_HZ / 1000000)))
`define SDD_MIN_PULSE_NS 2500
`define SDD_DIR_SETUP_NS 5000
`define SDD_IDLE_PCT 60
`define SDD_FULL_PCT 100
`define SDD_PCT_W 7
// register map, word offsets in bytes
`define SDD_CTRL_OFS 4'h0
`define SDD_STAT_OFS 4'h4
`define SDD_CNT_OFS 4'h8
// control fields
`define SDD_CTRL_MODE 0
`define SDD_CTRL_FALL 1
`define SDD_CTRL_LOWACT 2
`define SDD_CTRL_IDLE 3
`define SDD_CTRL_RST 4'h0
`endif

// *** rtl/sdd_pkg.sv ***
// types for the step and direction input decoder
package sdd_pkg;
  typedef enum logic [1:0] {
    SDD_PULSE_DIR = 2'b00,
    SDD_TWO_PULSE = 2'b01
  } sdd_mode_t;
  typedef enum logic [1:0] {
    SDD_RUN = 2'b00,
    SDD_WAIT = 2'b01,
    SDD_IDLE = 2'b11
  } sdd_cur_t;
endpackage

// *** rtl/sdd_sync.sv ***
// two-stage synchroniser with edge detect
`timescale 1ns/100ps
module sdd_sync (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic async_in,
  output logic level_q,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic prev_q;
  // ****************************************************************
  // synchroniser
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 1'b0;
      level_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      level_q <= meta_q;
      prev_q <= level_q;
    end
  end
  assign rise = level_q & ~prev_q;
  assign fall = ~level_q & prev_q;
endmodule

// *** rtl/sdd_decoder.sv ***
// step and direction input decoder with register slave
//
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "sdd_params.svh"
module sdd_decoder #(
  parameter int IDLE_CYC = `SDD_IDLE_CYC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic step_pulse_in,
  input wire logic dir_in,
  input wire logic drive_run_permit_in,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic step_evt_q,
  output logic step_dir_q,
  output logic drive_enable_q,
  output logic [`SDD_PCT_W-1:0] current_pct_q
);
  import sdd_pkg::*;
  if (IDLE_CYC < 1) begin : g_idle_chk
    $error("idle count must be at least one");
  end
  // ****************************************************************
  // helpers
  // ****************************************************************
  // choose the falling or the rising event of a synchronised pin
  function automatic logic pick_edge(input logic use_fall, input logic rise, input logic fall);
    return use_fall ? fall : rise;
  endfunction
  logic step_lvl;
  logic step_rise;
  logic step_fall;
  logic dir_lvl;
  logic dir_rise;
  logic dir_fall;
  logic ena_lvl;
  logic [3:0] ctrl_q;
  logic ctrl_wr;
  logic [31:0] step_cnt_q;
  logic [31:0] idle_cnt_q;
  sdd_cur_t cur_q;
  sdd_mode_t mode;
  logic step_d;
  logic dir_d;
  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  sdd_sync u_step (
    .ref_clk(ref_clk), .reset_n(reset_n), .async_in(step_pulse_in),
    .level_q(step_lvl), .rise(step_rise), .fall(step_fall)
  );
  sdd_sync u_dir (
    .ref_clk(ref_clk), .reset_n(reset_n), .async_in(dir_in),
    .level_q(dir_lvl), .rise(dir_rise), .fall(dir_fall)
  );
  sdd_sync u_ena (
    .ref_clk(ref_clk), .reset_n(reset_n), .async_in(drive_run_permit_in),
    .level_q(ena_lvl), .rise(), .fall()
  );
  // ****************************************************************
  // register slave
  // ****************************************************************
  assign mode = ctrl_q[`SDD_CTRL_MODE] ? SDD_TWO_PULSE : SDD_PULSE_DIR;
  // a write lands only at the edge where the master sees waitrequest low
  assign ctrl_wr = avs_write & ~avs_waitrequest & (avs_address == `SDD_CTRL_OFS)
                 & avs_byteenable[0];
  // waitrequest rests high and drops for one cycle per request
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= `SDD_CTRL_RST;
      avs_readdata <= 32'h0000_0000;
    end else begin
      if (ctrl_wr) begin
        ctrl_q <= avs_writedata[3:0];
      end
      if (avs_read && avs_waitrequest) begin
        unique case (avs_address)
          `SDD_CTRL_OFS: avs_readdata <= {28'h0000000, ctrl_q};
          `SDD_STAT_OFS: avs_readdata <= {28'h0000000, cur_q == SDD_IDLE, drive_enable_q,
                                          step_dir_q, step_lvl};
          `SDD_CNT_OFS: avs_readdata <= step_cnt_q;
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  // ****************************************************************
  // step decode
  // ****************************************************************
  always_comb begin
    step_d = 1'b0;
    dir_d = step_dir_q;
    if (mode == SDD_PULSE_DIR) begin
      step_d = pick_edge(ctrl_q[`SDD_CTRL_FALL], step_rise, step_fall);
      dir_d = dir_lvl;
    end else if (pick_edge(ctrl_q[`SDD_CTRL_LOWACT], step_rise, step_fall)) begin
      step_d = 1'b1;
      dir_d = 1'b0;
    end else if (pick_edge(ctrl_q[`SDD_CTRL_LOWACT], dir_rise, dir_fall)) begin
      step_d = 1'b1;
      dir_d = 1'b1;
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      step_evt_q <= 1'b0;
      step_dir_q <= 1'b0;
      drive_enable_q <= 1'b0;
      step_cnt_q <= 32'h0000_0000;
    end else begin
      drive_enable_q <= ena_lvl;
      step_evt_q <= step_d & ena_lvl;
      step_dir_q <= dir_d;
      if (step_d && ena_lvl) begin
        step_cnt_q <= step_cnt_q + 32'h0000_0001;
      end
    end
  end
  // ****************************************************************
  // idle current reduction
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_q <= SDD_RUN;
      idle_cnt_q <= 32'h0000_0000;
      current_pct_q <= `SDD_PCT_W'(`SDD_FULL_PCT);
    end else begin
      if (step_evt_q || !ctrl_q[`SDD_CTRL_IDLE]) begin
        cur_q <= SDD_RUN;
        idle_cnt_q <= 32'h0000_0000;
        current_pct_q <= `SDD_PCT_W'(`SDD_FULL_PCT);
      end else begin
        unique case (cur_q)
          SDD_RUN: cur_q <= SDD_WAIT;
          SDD_WAIT: begin
            if (idle_cnt_q >= 32'(IDLE_CYC - 1)) begin
              cur_q <= SDD_IDLE;
              current_pct_q <= `SDD_PCT_W'(`SDD_IDLE_PCT);
            end else begin
              idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
            end
          end
          SDD_IDLE: cur_q <= SDD_IDLE;
          default: cur_q <= SDD_RUN;
        endcase
      end
    end
  end
  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence rise_seen_s;
    step_rise && mode == SDD_PULSE_DIR && !ctrl_q[`SDD_CTRL_FALL] && ena_lvl;
  endsequence
  step_on_edge_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rise_seen_s |=> step_evt_q) else $error("rising edge gave no step");
  dir_follows_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    mode == SDD_PULSE_DIR |=> step_dir_q == $past(dir_lvl)) else $error("direction wrong");
  fwd_pulse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (mode == SDD_TWO_PULSE && !ctrl_q[`SDD_CTRL_LOWACT] && step_rise && ena_lvl)
    |=> step_evt_q && !step_dir_q) else $error("forward pulse lost");
  rev_pulse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (mode == SDD_TWO_PULSE && !ctrl_q[`SDD_CTRL_LOWACT] && dir_rise && !step_rise && ena_lvl)
    |=> step_evt_q && step_dir_q) else $error("reverse pulse lost");
  enable_track_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ##1 drive_enable_q == $past(ena_lvl)) else $error("enable not tracked");
  no_step_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !ena_lvl |=> !step_evt_q) else $error("step while disabled");
  single_step_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    step_evt_q && mode == SDD_PULSE_DIR |=> !step_evt_q) else $error("double step");
  idle_current_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cur_q == SDD_IDLE |-> current_pct_q == `SDD_PCT_W'(`SDD_IDLE_PCT)) else $error("idle pct");
  sequence fall_seen_s;
    step_fall && mode == SDD_PULSE_DIR && ctrl_q[`SDD_CTRL_FALL] && ena_lvl;
  endsequence
  sequence fwd_low_s;
    mode == SDD_TWO_PULSE && ctrl_q[`SDD_CTRL_LOWACT] && step_fall && ena_lvl;
  endsequence
  sequence rev_low_s;
    mode == SDD_TWO_PULSE && ctrl_q[`SDD_CTRL_LOWACT] && dir_fall && !step_fall && ena_lvl;
  endsequence
  fall_edge_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fall_seen_s |=> step_evt_q) else $error("falling edge gave no step");
  rise_only_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    mode == SDD_PULSE_DIR && !ctrl_q[`SDD_CTRL_FALL] && !step_rise |=> !step_evt_q)
    else $error("step on inactive edge");
  fall_only_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    mode == SDD_PULSE_DIR && ctrl_q[`SDD_CTRL_FALL] && !step_fall |=> !step_evt_q)
    else $error("step on inactive edge");
  fwd_low_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fwd_low_s |=> step_evt_q && !step_dir_q) else $error("low forward pulse lost");
  rev_low_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rev_low_s |=> step_evt_q && step_dir_q) else $error("low reverse pulse lost");
  step_count_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    step_evt_q |-> step_cnt_q == $past(step_cnt_q) + 32'h0000_0001)
    else $error("step count missed");
  dir_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    mode == SDD_TWO_PULSE && ena_lvl ##1 !step_evt_q |-> $stable(step_dir_q))
    else $error("direction moved without a step");
  full_current_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !ctrl_q[`SDD_CTRL_IDLE] |=> current_pct_q == `SDD_PCT_W'(`SDD_FULL_PCT))
    else $error("current reduced while reduction off");
  wake_full_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    step_evt_q |=> current_pct_q == `SDD_PCT_W'(`SDD_FULL_PCT)) else $error("no full current");
  // ****************************************************************
  // quiet time counter for the idle check
  // ****************************************************************
  logic [31:0] quiet_cnt_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      quiet_cnt_q <= 32'h0000_0000;
    end else if (step_evt_q || !ctrl_q[`SDD_CTRL_IDLE]) begin
      quiet_cnt_q <= 32'h0000_0000;
    end else if (quiet_cnt_q != 32'hFFFF_FFFF) begin
      quiet_cnt_q <= quiet_cnt_q + 32'h0000_0001;
    end
  end
  idle_reached_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    quiet_cnt_q > 32'(IDLE_CYC + 1) |-> current_pct_q == `SDD_PCT_W'(`SDD_IDLE_PCT))
    else $error("idle current not reduced");
endmodule

// *** verif/sdd_ctl_model.sv ***
// motion controller model driving the step, direction and run permit pins
`timescale 1ns/100ps
module sdd_ctl_model (
  input wire logic ref_clk,
  output logic step_o,
  output logic dir_o,
  output logic permit_o
);
  initial begin
    step_o = 1'b0;
    dir_o = 1'b0;
    permit_o = 1'b1; // driven high from the start, so it reads as run
  end
  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // each step level is held for longer than 2.5 us
  task automatic set_step(input logic v);
    step_o <= v;
    hold(101);
  endtask
  // the direction settles 5 us before the next step
  task automatic set_dir(input logic v);
    dir_o <= v;
    hold(200);
  endtask
  task automatic set_permit(input logic v);
    permit_o <= v;
    hold(101);
  endtask
endmodule

// *** verif/tb.sv ***
// self-checking bench for the step and direction decoder
`timescale 1ns/100ps
`include "sdd_params.svh"
module tb;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic avs_waitrequest, step_evt_q, step_dir_q, drive_enable_q, stp, dir, ena, last_dir;
  logic [`SDD_PCT_W-1:0] current_pct_q;
  int error_cnt = 0;
  int n_checks = 0;
  int evt_n = 0;
  initial forever #12.5 ref_clk = ~ref_clk;
  sdd_ctl_model sdd_ctl_model_i (.ref_clk(ref_clk), .step_o(stp), .dir_o(dir), .permit_o(ena));
  sdd_decoder #(.IDLE_CYC(8)) sdd_decoder_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .step_pulse_in(stp), .dir_in(dir), .drive_run_permit_in(ena), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .step_evt_q(step_evt_q), .step_dir_q(step_dir_q), .drive_enable_q(drive_enable_q),
    .current_pct_q(current_pct_q));
  // ****
  // step event tally
  // ****
  always @(posedge ref_clk) if (step_evt_q === 1'b1) begin
    evt_n <= evt_n + 1;
    last_dir <= step_dir_q;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int i;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i < 20) begin
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
    end else begin
      error_cnt++;
      print_verdict();
    end
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    bus(0, 4'h0, 0, 4'hF);
    chk(rd, 32'h0);
    chk(current_pct_q, 32'h64);
    sdd_ctl_model_i.set_dir(1);
    sdd_ctl_model_i.set_step(1);
    chk(evt_n, 1);
    chk(last_dir, 1);
    bus(0, 4'h4, 0, 4'hF);
    chk(rd, 32'h7);
    sdd_ctl_model_i.set_step(0);
    chk(evt_n, 1);
    bus(0, 4'h8, 0, 4'hF);
    chk(rd, 32'h1);
    bus(1, 4'h0, 32'h2, 4'hF);
    bus(1, 4'h0, 32'hD, 4'hE);
    bus(1, 4'h4, 32'hD, 4'hF);
    bus(0, 4'h0, 0, 4'hF);
    chk(rd, 32'h2);
    sdd_ctl_model_i.set_step(1);
    chk(evt_n, 1);
    sdd_ctl_model_i.set_step(0);
    chk(evt_n, 2);
    sdd_ctl_model_i.set_dir(0);
    sdd_ctl_model_i.set_step(1);
    sdd_ctl_model_i.set_step(0);
    chk(last_dir, 0);
    bus(1, 4'h0, 32'h1, 4'hF);
    sdd_ctl_model_i.set_step(1);
    chk(evt_n, 4);
    chk(last_dir, 0);
    sdd_ctl_model_i.set_step(0);
    sdd_ctl_model_i.set_dir(1);
    chk(evt_n, 5);
    chk(last_dir, 1);
    sdd_ctl_model_i.set_dir(0);
    bus(1, 4'h0, 32'hFFFF_FFF5, 4'hF);
    bus(0, 4'h0, 0, 4'hF);
    chk(rd, 32'h5);
    sdd_ctl_model_i.set_step(1);
    chk(evt_n, 5);
    sdd_ctl_model_i.set_step(0);
    chk(evt_n, 6);
    chk(last_dir, 0);
    sdd_ctl_model_i.set_dir(1);
    sdd_ctl_model_i.set_dir(0);
    chk(evt_n, 7);
    chk(last_dir, 1);
    bus(1, 4'h0, 32'h8, 4'hF);
    sdd_ctl_model_i.set_permit(0);
    chk(drive_enable_q, 0);
    sdd_ctl_model_i.set_step(1);
    sdd_ctl_model_i.set_step(0);
    chk(evt_n, 7);
    sdd_ctl_model_i.set_permit(1);
    chk(drive_enable_q, 1);
    chk(current_pct_q, 32'h3C);
    sdd_ctl_model_i.step_o <= 1'b1;
    sdd_ctl_model_i.hold(6);
    chk(current_pct_q, 32'h64);
    sdd_ctl_model_i.hold(100);
    sdd_ctl_model_i.set_step(0);
    chk(evt_n, 8);
    bus(0, 4'hC, 0, 4'hF);
    chk(rd, 32'h0);
    print_verdict();
  end
endmodule
